// ===== verilog/gpio_buf_pkg.sv
package gpio_buf_pkg;
  localparam int          NPORT       = 5;
  localparam int          P1          = 0;
  localparam int          P2          = 1;
  localparam int          P6          = 2;
  localparam int          PA          = 3;
  localparam int          PH          = 4;
  localparam logic [7:0]  VALID_MASK [NPORT] = '{8'hff, 8'h0f, 8'h7f, 8'hfe, 8'hff};
  localparam logic [7:0]  RESET_VAL   = 8'h00;
  // Per-port word block: base is port index times 16
  localparam logic [3:0]  OFF_DIR     = 4'h0;
  localparam logic [3:0]  OFF_LATCH   = 4'h4;
  localparam logic [3:0]  OFF_RDBK    = 4'h8;
  localparam logic [3:0]  OFF_IBE     = 4'hc;
  localparam logic [7:0]  ADDR_PULLUP = 8'h50;
  localparam logic [7:0]  ADDR_ODS    = 8'h54;
  localparam logic [7:0]  ADDR_SNAP   = 8'h58;
  localparam logic [7:0]  ADDR_SENSE  = 8'h5c;
  localparam logic [7:0]  ODS_MASK    = 8'h0f;
  localparam int          CLK_PIN_BIT = 6;
  localparam int          TX_PIN_BIT  = 4;
  localparam logic [1:0]  SENSE_LOW   = 2'h0;
  localparam logic [1:0]  SENSE_FALL  = 2'h1;
  localparam logic [1:0]  SENSE_RISE  = 2'h2;
  localparam logic [1:0]  SENSE_BOTH  = 2'h3;
endpackage

// ===== verilog/gpio_pin_buffer_control.sv
`timescale 1ns/100ps
module gpio_pin_buffer_control (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        serial_clock_out_enable_i,
  input  wire logic        serial_clock_out_i,
  input  wire logic        serial_tx_out_enable_i,
  input  wire logic        serial_tx_out_i,
  input  wire logic        snapshot_trigger_pin_i,
  input  wire logic [7:0]  p1_pin_i,
  input  wire logic [7:0]  p2_pin_i,
  input  wire logic [7:0]  p6_pin_i,
  input  wire logic [7:0]  pa_pin_i,
  input  wire logic [7:0]  ph_pin_i,
  output logic      [7:0]  p1_pin_o,
  output logic      [7:0]  p2_pin_o,
  output logic      [7:0]  p6_pin_o,
  output logic      [7:0]  pa_pin_o,
  output logic      [7:0]  ph_pin_o,
  output logic      [7:0]  p1_pin_oe_o,
  output logic      [7:0]  p2_pin_oe_o,
  output logic      [7:0]  p6_pin_oe_o,
  output logic      [7:0]  pa_pin_oe_o,
  output logic      [7:0]  ph_pin_oe_o,
  output logic      [7:0]  p1_periph_in_o,
  output logic      [7:0]  p2_periph_in_o,
  output logic      [7:0]  p6_periph_in_o,
  output logic      [7:0]  pa_periph_in_o,
  output logic      [7:0]  ph_periph_in_o,
  output logic      [7:0]  ph_pullup_on_o
);

  logic       rst_sync1_r;
  logic       rst_sync2_r;
  logic       rst_n;
  logic [7:0] pin_raw      [gpio_buf_pkg::NPORT];
  logic [7:0] pin_sync1_r  [gpio_buf_pkg::NPORT];
  logic [7:0] pin_sync2_r  [gpio_buf_pkg::NPORT];
  logic [7:0] dir_r        [gpio_buf_pkg::NPORT];
  logic [7:0] latch_r      [gpio_buf_pkg::NPORT];
  logic [7:0] ibe_r        [gpio_buf_pkg::NPORT];
  logic [7:0] drv_en_nxt   [gpio_buf_pkg::NPORT];
  logic [7:0] drv_val_nxt  [gpio_buf_pkg::NPORT];
  logic [7:0] pin_out_r    [gpio_buf_pkg::NPORT];
  logic [7:0] pin_oe_r     [gpio_buf_pkg::NPORT];
  logic [7:0] periph_in_r  [gpio_buf_pkg::NPORT];
  logic [7:0] pullup_r;
  logic [7:0] ods_r;
  logic [7:0] snap_r;
  logic [1:0] sense_r;
  logic [7:0] pullup_on_r;
  logic       trig_sync1_r;
  logic       trig_sync2_r;
  logic       trig_prev_r;
  logic       trig_hit;
  logic       wait_r;
  logic [31:0] rdata_r;
  logic       wr_go;
  logic       rd_go;

  // Reset asserts at once, releases after two clocks
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  assign pin_raw[gpio_buf_pkg::P1] = p1_pin_i;
  assign pin_raw[gpio_buf_pkg::P2] = p2_pin_i;
  assign pin_raw[gpio_buf_pkg::P6] = p6_pin_i;
  assign pin_raw[gpio_buf_pkg::PA] = pa_pin_i;
  assign pin_raw[gpio_buf_pkg::PH] = ph_pin_i;

  // Pins are asynchronous to the system clock
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        pin_sync1_r[k] <= 8'h00;
        pin_sync2_r[k] <= 8'h00;
      end
    end else if (ce_i) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        pin_sync1_r[k] <= pin_raw[k];
        pin_sync2_r[k] <= pin_sync1_r[k];
      end
    end
  end

  // Trigger idles high, so reset high to avoid a false edge
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync1_r <= 1'b1;
      trig_sync2_r <= 1'b1;
      trig_prev_r  <= 1'b1;
    end else if (ce_i) begin
      trig_sync1_r <= snapshot_trigger_pin_i;
      trig_sync2_r <= trig_sync1_r;
      trig_prev_r  <= trig_sync2_r;
    end
  end

  function automatic logic [7:0] lane(input logic [31:0] d, input int k);
    lane = d[7:0] & gpio_buf_pkg::VALID_MASK[k];
  endfunction

  function automatic logic port_sel(input logic [7:0] a, input int k, input logic [3:0] off);
    port_sel = (a[7:4] == 4'(k)) && (a[3:0] == off);
  endfunction

  // Buffer enable deliberately not applied here
  function automatic logic [7:0] rdbk(input logic [7:0] d, input logic [7:0] q, input logic [7:0] p,
                                      input int k);
    rdbk = ((d & q) | (~d & p)) & gpio_buf_pkg::VALID_MASK[k];
  endfunction

  // Bus: one wait cycle, then the answer edge
  assign wr_go = avs_write_i & ~wait_r & avs_byteenable_i[0];
  assign rd_go = avs_read_i & wait_r;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if (ce_i) begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        dir_r[k]   <= gpio_buf_pkg::RESET_VAL;
        latch_r[k] <= gpio_buf_pkg::RESET_VAL;
        ibe_r[k]   <= gpio_buf_pkg::RESET_VAL;
      end
    end else if (ce_i && wr_go) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        if (port_sel(avs_address_i, k, gpio_buf_pkg::OFF_DIR)) begin
          dir_r[k] <= lane(avs_writedata_i, k);
        end else if (port_sel(avs_address_i, k, gpio_buf_pkg::OFF_LATCH)) begin
          latch_r[k] <= lane(avs_writedata_i, k);
        end else if (port_sel(avs_address_i, k, gpio_buf_pkg::OFF_IBE)) begin
          ibe_r[k] <= lane(avs_writedata_i, k);
        end
      end
    end
  end

  // Pull-up register exists for group H only
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pullup_r <= gpio_buf_pkg::RESET_VAL;
    end else if (ce_i && wr_go && avs_address_i == gpio_buf_pkg::ADDR_PULLUP) begin
      pullup_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ods_r <= gpio_buf_pkg::RESET_VAL;
    end else if (ce_i && wr_go && avs_address_i == gpio_buf_pkg::ADDR_ODS) begin
      ods_r <= avs_writedata_i[7:0] & gpio_buf_pkg::ODS_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sense_r <= gpio_buf_pkg::SENSE_LOW;
    end else if (ce_i && wr_go && avs_address_i == gpio_buf_pkg::ADDR_SENSE) begin
      sense_r <= avs_writedata_i[1:0];
    end
  end

  // Read data latched while wait is high, stands at the answer edge
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce_i && rd_go) begin
      rdata_r <= 32'h0000_0000;
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        if (avs_address_i[7:4] == 4'(k)) begin
          if (avs_address_i[3:0] == gpio_buf_pkg::OFF_LATCH) begin
            rdata_r[7:0] <= latch_r[k];
          end else if (avs_address_i[3:0] == gpio_buf_pkg::OFF_RDBK) begin
            rdata_r[7:0] <= rdbk(dir_r[k], latch_r[k], pin_sync2_r[k], k);
          end else if (avs_address_i[3:0] == gpio_buf_pkg::OFF_IBE) begin
            rdata_r[7:0] <= ibe_r[k];
          end
        end
      end
      if (avs_address_i == gpio_buf_pkg::ADDR_PULLUP) begin
        rdata_r[7:0] <= pullup_r;
      end else if (avs_address_i == gpio_buf_pkg::ADDR_ODS) begin
        rdata_r[7:0] <= ods_r;
      end else if (avs_address_i == gpio_buf_pkg::ADDR_SNAP) begin
        rdata_r[7:0] <= snap_r;
      end else if (avs_address_i == gpio_buf_pkg::ADDR_SENSE) begin
        rdata_r[1:0] <= sense_r;
      end
    end
  end

  // Output selection per pin
  always_comb begin
    for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
      drv_en_nxt[k]  = dir_r[k] & gpio_buf_pkg::VALID_MASK[k];
      drv_val_nxt[k] = latch_r[k];
    end
    if (serial_clock_out_enable_i) begin
      drv_en_nxt[gpio_buf_pkg::P1][gpio_buf_pkg::CLK_PIN_BIT]  = 1'b1;
      drv_val_nxt[gpio_buf_pkg::P1][gpio_buf_pkg::CLK_PIN_BIT] = serial_clock_out_i;
    end
    if (serial_tx_out_enable_i) begin
      drv_en_nxt[gpio_buf_pkg::P1][gpio_buf_pkg::TX_PIN_BIT]  = 1'b1;
      drv_val_nxt[gpio_buf_pkg::P1][gpio_buf_pkg::TX_PIN_BIT] = serial_tx_out_i;
    end
    // Open drain: enable only while driving a low
    drv_en_nxt[gpio_buf_pkg::P2] = drv_en_nxt[gpio_buf_pkg::P2]
                                   & ~(ods_r & drv_val_nxt[gpio_buf_pkg::P2]);
    drv_val_nxt[gpio_buf_pkg::P2] = drv_val_nxt[gpio_buf_pkg::P2] & ~ods_r;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        pin_out_r[k] <= 8'h00;
        pin_oe_r[k]  <= 8'h00;
      end
    end else if (ce_i) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        pin_out_r[k] <= drv_val_nxt[k];
        pin_oe_r[k]  <= drv_en_nxt[k];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        periph_in_r[k] <= 8'hff;
      end
    end else if (ce_i) begin
      for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
        // Peripherals see a steady high while the buffer is off
        periph_in_r[k] <= pin_sync2_r[k] | ~ibe_r[k];
      end
    end
  end

  // No peripheral outputs on group H, so driven means direction set
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pullup_on_r <= 8'h00;
    end else if (ce_i) begin
      pullup_on_r <= pullup_r & ~dir_r[gpio_buf_pkg::PH];
    end
  end

  // Level sense latches every cycle while the trigger is low
  always_comb begin
    case (sense_r)
      gpio_buf_pkg::SENSE_LOW:  trig_hit = ~trig_sync2_r;
      gpio_buf_pkg::SENSE_FALL: trig_hit = trig_prev_r & ~trig_sync2_r;
      gpio_buf_pkg::SENSE_RISE: trig_hit = ~trig_prev_r & trig_sync2_r;
      default:                  trig_hit = trig_prev_r ^ trig_sync2_r;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= 8'h00;
    end else if (ce_i && trig_hit) begin
      snap_r <= pin_sync2_r[gpio_buf_pkg::PH];
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign p1_pin_o          = pin_out_r[gpio_buf_pkg::P1];
  assign p2_pin_o          = pin_out_r[gpio_buf_pkg::P2];
  assign p6_pin_o          = pin_out_r[gpio_buf_pkg::P6];
  assign pa_pin_o          = pin_out_r[gpio_buf_pkg::PA];
  assign ph_pin_o          = pin_out_r[gpio_buf_pkg::PH];
  assign p1_pin_oe_o       = pin_oe_r[gpio_buf_pkg::P1];
  assign p2_pin_oe_o       = pin_oe_r[gpio_buf_pkg::P2];
  assign p6_pin_oe_o       = pin_oe_r[gpio_buf_pkg::P6];
  assign pa_pin_oe_o       = pin_oe_r[gpio_buf_pkg::PA];
  assign ph_pin_oe_o       = pin_oe_r[gpio_buf_pkg::PH];
  assign p1_periph_in_o    = periph_in_r[gpio_buf_pkg::P1];
  assign p2_periph_in_o    = periph_in_r[gpio_buf_pkg::P2];
  assign p6_periph_in_o    = periph_in_r[gpio_buf_pkg::P6];
  assign pa_periph_in_o    = periph_in_r[gpio_buf_pkg::PA];
  assign ph_periph_in_o    = periph_in_r[gpio_buf_pkg::PH];
  assign ph_pullup_on_o    = pullup_on_r;

endmodule // gpio_pin_buffer_control

// ===== bench/gpio_buf_monitor.sv
`timescale 1ns/100ps
module gpio_buf_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        serial_clock_out_enable_i,
  input wire logic        serial_clock_out_i,
  input wire logic        serial_tx_out_enable_i,
  input wire logic        serial_tx_out_i,
  input wire logic [7:0]  p1_pin_o,
  input wire logic [7:0]  p1_pin_oe_o,
  input wire logic [7:0]  p2_pin_oe_o,
  input wire logic [7:0]  ph_pin_oe_o,
  input wire logic [7:0]  ph_pullup_on_o
);
  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  clk_owner_a: assert property (
    serial_clock_out_enable_i |=> p1_pin_oe_o[6] && p1_pin_o[6] == $past(serial_clock_out_i))
    else $error("serial clock pin not owned");
  tx_owner_a: assert property (
    serial_tx_out_enable_i |=> p1_pin_oe_o[4] && p1_pin_o[4] == $past(serial_tx_out_i))
    else $error("transmit pin not owned");
  one_wait_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer out of step");
  rdata_high_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  reserved_oe_a: assert property (p2_pin_oe_o[7:4] == 4'h0)
    else $error("reserved pin driven");
  pullup_off_a: assert property ((ph_pullup_on_o & ph_pin_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");
  // Only a taken direction write may move a plain pin
  plain_dir_a: assert property ($changed(p1_pin_oe_o[7]) |->
    $past(avs_write_i && !avs_waitrequest_o && avs_address_i == {4'h0, gpio_buf_pkg::OFF_DIR}, 2))
    else $error("plain pin moved without write");
  pullup_write_a: assert property ($changed(ph_pullup_on_o) |-> $past(avs_write_i && !avs_waitrequest_o, 2))
    else $error("pull-up moved without write");
endmodule // gpio_buf_monitor

bind gpio_pin_buffer_control gpio_buf_monitor mon_u (.*);

// ===== bench/pin_side_model.sv
`timescale 1ns/100ps
module pin_side_model (
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  output logic      [7:0] level_o
);
  // Released open-drain bits fall back to the far-side drive
  assign level_o = (oe_i & pin_o_i) | (~oe_i & (pullup_i | drive_i));
endmodule // pin_side_model

// ===== bench/gpio_pin_buffer_control_test.sv
`timescale 1ns/100ps
module gpio_pin_buffer_control_test;
  logic        sys_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        serial_clock_out_enable_i = 1'b0, serial_clock_out_i = 1'b0, avs_waitrequest_o;
  logic        serial_tx_out_enable_i = 1'b0, serial_tx_out_i = 1'b0, snapshot_trigger_pin_i = 1'b1;
  logic [3:0]  avs_byteenable_i = 4'h1;
  logic [7:0]  avs_address_i = 8'h00, ext1 = 8'ha5, ext2 = 8'h0c, exth = 8'h00, rd;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [7:0]  p1_pin_i, p2_pin_i, p6_pin_i, pa_pin_i, ph_pin_i, p1_pin_o, p2_pin_o, p6_pin_o, pa_pin_o;
  logic [7:0]  ph_pin_o, p1_pin_oe_o, p2_pin_oe_o, p6_pin_oe_o, pa_pin_oe_o, ph_pin_oe_o, ph_pullup_on_o;
  logic [7:0]  p1_periph_in_o, p2_periph_in_o, p6_periph_in_o, pa_periph_in_o, ph_periph_in_o;
  int          err_total = 0, checks_done = 0;
  localparam logic [7:0] a1_dir = {4'h0, gpio_buf_pkg::OFF_DIR};
  localparam logic [7:0] a1_lat = {4'h0, gpio_buf_pkg::OFF_LATCH};
  localparam logic [7:0] a1_rdb = {4'h0, gpio_buf_pkg::OFF_RDBK};
  localparam logic [7:0] a1_ibe = {4'h0, gpio_buf_pkg::OFF_IBE};
  localparam logic [7:0] a2_dir = {4'h1, gpio_buf_pkg::OFF_DIR};
  localparam logic [7:0] a2_lat = {4'h1, gpio_buf_pkg::OFF_LATCH};
  localparam logic [7:0] ah_dir = {4'h4, gpio_buf_pkg::OFF_DIR};

  assign p6_pin_i = ext1;
  assign pa_pin_i = ext2;
  gpio_pin_buffer_control dut_u (.*);
  pin_side_model p1_far_u (.drive_i(ext1), .pin_o_i(p1_pin_o), .oe_i(p1_pin_oe_o), .pullup_i(8'h00),
                           .level_o(p1_pin_i));
  pin_side_model p2_far_u (.drive_i(ext2), .pin_o_i(p2_pin_o), .oe_i(p2_pin_oe_o), .pullup_i(8'h00),
                           .level_o(p2_pin_i));
  pin_side_model ph_far_u (.drive_i(exth), .pin_o_i(ph_pin_o), .oe_i(ph_pin_oe_o), .pullup_i(ph_pullup_on_o),
                           .level_o(ph_pin_i));

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge sys_clk_i);
      n++;
    end
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
    if (n == 50) begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp(rd, e);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (int k = 0; k < gpio_buf_pkg::NPORT; k++) begin
      rchk({4'(k), gpio_buf_pkg::OFF_IBE}, 8'h00);
      bus(1'b1, {4'(k), gpio_buf_pkg::OFF_IBE}, 8'hff);
      rchk({4'(k), gpio_buf_pkg::OFF_IBE}, gpio_buf_pkg::VALID_MASK[k]);
      rchk({4'(k), gpio_buf_pkg::OFF_DIR}, 8'h00);
    end
    rchk(gpio_buf_pkg::ADDR_PULLUP, 8'h00);
    bus(1'b1, gpio_buf_pkg::ADDR_SNAP, 8'hff);
    rchk(gpio_buf_pkg::ADDR_SNAP, 8'h00);
    rchk(gpio_buf_pkg::ADDR_ODS, 8'h00);
    bus(1'b1, gpio_buf_pkg::ADDR_ODS, 8'hff);
    rchk(gpio_buf_pkg::ADDR_ODS, gpio_buf_pkg::ODS_MASK);
    rchk(8'h60, 8'h00);
    $display("test registers done");
    cmp(p1_periph_in_o, 8'ha5);
    cmp(p2_periph_in_o, 8'hfc);
    cmp(p6_periph_in_o, 8'ha5);
    cmp(pa_periph_in_o, 8'h0d);
    cmp(ph_periph_in_o, 8'h00);
    bus(1'b1, a1_ibe, 8'h00);
    ext1 <= 8'h3c;
    repeat (5) @(posedge sys_clk_i);
    cmp(p1_periph_in_o, 8'hff);
    rchk(a1_rdb, 8'h3c);
    $display("test buffer done");
    bus(1'b1, a1_lat, 8'h96);
    bus(1'b1, a1_dir, 8'h8f);
    repeat (2) @(posedge sys_clk_i);
    cmp(p1_pin_oe_o, 8'h8f);
    rchk(a1_rdb, 8'hb6);
    serial_clock_out_enable_i <= 1'b1;
    serial_clock_out_i <= 1'b1;
    serial_tx_out_enable_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    cmp(p1_pin_oe_o, 8'hdf);
    cmp(p1_pin_o & 8'h50, 8'h40);
    serial_clock_out_enable_i <= 1'b0;
    serial_tx_out_enable_i <= 1'b0;
    bus(1'b1, a1_dir, 8'h50);
    repeat (2) @(posedge sys_clk_i);
    cmp(p1_pin_oe_o, 8'h50);
    cmp(p1_pin_o & 8'h50, 8'h10);
    $display("test direction done");
    bus(1'b1, a2_lat, 8'h05);
    bus(1'b1, a2_dir, 8'h0f);
    repeat (2) @(posedge sys_clk_i);
    cmp(p2_pin_oe_o, 8'h0a);
    cmp(p2_pin_o & p2_pin_oe_o, 8'h00);
    bus(1'b1, gpio_buf_pkg::ADDR_ODS, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    cmp(p2_pin_oe_o, 8'h0f);
    cmp(p2_pin_o & 8'h0f, 8'h05);
    bus(1'b1, {4'h3, gpio_buf_pkg::OFF_DIR}, 8'hff);
    repeat (2) @(posedge sys_clk_i);
    cmp(pa_pin_oe_o, 8'hfe);
    cmp(p6_pin_oe_o | pa_pin_o | p6_pin_o, 8'h00);
    $display("test open drain done");
    // Trigger parked high first, low in rise mode, so in the edge modes only the toggle latches; level-low keeps latching while low
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, gpio_buf_pkg::ADDR_SENSE, 8'(s));
      snapshot_trigger_pin_i <= (s != 2);
      exth <= {4'(s), 4'ha};
      repeat (6) @(posedge sys_clk_i);
      snapshot_trigger_pin_i <= ~snapshot_trigger_pin_i;
      repeat (6) @(posedge sys_clk_i);
      rchk(gpio_buf_pkg::ADDR_SNAP, {4'(s), 4'ha});
      exth <= 8'hc5;
      repeat (6) @(posedge sys_clk_i);
      if (s != 0) begin
        rchk(gpio_buf_pkg::ADDR_SNAP, {4'(s), 4'ha});
      end
    end
    $display("test snapshot done");
    bus(1'b1, gpio_buf_pkg::ADDR_PULLUP, 8'hff);
    bus(1'b1, ah_dir, 8'h0f);
    repeat (2) @(posedge sys_clk_i);
    cmp(ph_pullup_on_o, 8'hf0);
    cmp(ph_pin_oe_o | ph_pin_o, 8'h0f);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    cmp(ph_pullup_on_o, 8'h00);
    cmp(p1_pin_oe_o | ph_pin_oe_o, 8'h00);
    cmp(p1_periph_in_o, 8'hff);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rchk(gpio_buf_pkg::ADDR_PULLUP, 8'h00);
    $display("test pull-up done");
    wrap_up();
  end
endmodule // gpio_pin_buffer_control_test
